// [logic/hdo_pkg.sv]
// constants and types for the haptic drive option registers
package hdo_pkg;
   localparam logic [7:0] HDO_ADDR_DRIVE_OPT = 8'h1D;
   localparam logic [7:0] HDO_ADDR_CAL_NVM = 8'h1E;
   localparam logic [7:0] HDO_NVM_FIRST = 8'h16;
   localparam logic [7:0] HDO_NVM_LAST = 8'h1A;
   localparam int HDO_BIT_UPDATE_RATE = 2;
   localparam int HDO_BIT_INPUT_SEL = 1;
   localparam int HDO_BIT_OPEN_LOOP = 0;
   localparam int HDO_BIT_CAL_LO = 4;
   localparam int HDO_BIT_PROGRAMMED = 2;
   localparam int HDO_BIT_LAUNCH = 0;
   localparam logic [1:0] HDO_CAL_RESET = 2'h2;
   localparam logic [2:0] HDO_MODE_PIN_INPUT = 3'h3;
   localparam int HDO_COMM_DIVIDE = 128;
   localparam int HDO_DUTY_WINDOW = 255;
   typedef enum logic [1:0]
   {
      HDO_NVM_IDLE = 2'b00,
      HDO_NVM_BUSY = 2'b01,
      HDO_NVM_DONE = 2'b10
   } hdo_nvm_state_t;
   // calibration run time bounds in ms for each duration code
   function automatic logic [10:0] hdo_cal_min_ms(input logic [1:0] code);
      unique case (code)
         2'h0: hdo_cal_min_ms = 11'd150;
         2'h1: hdo_cal_min_ms = 11'd250;
         2'h2: hdo_cal_min_ms = 11'd500;
         2'h3: hdo_cal_min_ms = 11'd1000;
      endcase
   endfunction : hdo_cal_min_ms
   function automatic logic [10:0] hdo_cal_max_ms(input logic [1:0] code);
      unique case (code)
         2'h0: hdo_cal_max_ms = 11'd350;
         2'h1: hdo_cal_max_ms = 11'd450;
         2'h2: hdo_cal_max_ms = 11'd700;
         2'h3: hdo_cal_max_ms = 11'd1200;
      endcase
   endfunction : hdo_cal_max_ms
endpackage : hdo_pkg

// [logic/hdo_pin_if.sv]
// carrier between the pin meter and the option register core
`timescale 1ns/1ns
`default_nettype none
interface hdo_pin_if;
   logic [7:0] dutyLevel;
   logic dutyValid;
   logic commLevel;
   logic commHalfTick;
   modport meter (output dutyLevel, output dutyValid, output commLevel, output commHalfTick);
   modport core (input dutyLevel, input dutyValid, input commLevel, input commHalfTick);
endinterface : hdo_pin_if
`default_nettype wire

// [logic/hdo_pin_meter.sv]
// duty measurement and commutation divider on the input/trigger pin
`timescale 1ns/1ns
`default_nettype none
module hdo_pin_meter
   import hdo_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic input_trigger_pin,
   hdo_pin_if.meter pins
);
   localparam logic [7:0] WINDOW_LAST = 8'(HDO_DUTY_WINDOW - 1);
   localparam logic [5:0] HALF_LAST = 6'(HDO_COMM_DIVIDE / 2 - 1);
   logic pinLast_reg, pinLast_next;
   logic [7:0] winCount_reg, winCount_next;
   logic [7:0] highCount_reg, highCount_next;
   logic [7:0] duty_reg, duty_next;
   logic dutyValid_reg, dutyValid_next;
   logic [5:0] edgeCount_reg, edgeCount_next;
   logic comm_reg, comm_next;
   logic half_reg, half_next;
   logic rise;

   always_comb
   begin
      rise = input_trigger_pin && !pinLast_reg;
      pinLast_next = input_trigger_pin;
      // high samples over a 255-clock window give duty scaled to 0..255
      winCount_next = (winCount_reg == WINDOW_LAST) ? 8'h00 : winCount_reg + 8'h01;
      highCount_next = (winCount_reg == WINDOW_LAST) ? 8'h00
         : highCount_reg + {7'h00, input_trigger_pin};
      duty_next = duty_reg;
      dutyValid_next = 1'b0;
      if (winCount_reg == WINDOW_LAST)
      begin
         duty_next = highCount_reg + {7'h00, input_trigger_pin};
         dutyValid_next = 1'b1;
      end
      // toggling every 64 rising edges gives the pwm frequency over 128
      edgeCount_next = edgeCount_reg;
      comm_next = comm_reg;
      half_next = 1'b0;
      if (rise)
      begin
         edgeCount_next = (edgeCount_reg == HALF_LAST) ? 6'h00 : edgeCount_reg + 6'h01;
         if (edgeCount_reg == HALF_LAST)
         begin
            comm_next = !comm_reg;
            half_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pinLast_reg <= 1'b0;
         winCount_reg <= 8'h00;
         highCount_reg <= 8'h00;
         duty_reg <= 8'h00;
         dutyValid_reg <= 1'b0;
         edgeCount_reg <= 6'h00;
         comm_reg <= 1'b0;
         half_reg <= 1'b0;
      end
      else
      begin
         pinLast_reg <= pinLast_next;
         winCount_reg <= winCount_next;
         highCount_reg <= highCount_next;
         duty_reg <= duty_next;
         dutyValid_reg <= dutyValid_next;
         edgeCount_reg <= edgeCount_next;
         comm_reg <= comm_next;
         half_reg <= half_next;
      end
   end

   assign pins.dutyLevel = duty_reg;
   assign pins.dutyValid = dutyValid_reg;
   assign pins.commLevel = comm_reg;
   assign pins.commHalfTick = half_reg;
endmodule : hdo_pin_meter
`default_nettype wire

// [logic/hdo_drive_option_regs.sv]
// drive option and calibration/nvm control registers with amplitude steering
`timescale 1ns/1ns
`default_nettype none
module hdo_drive_option_regs
   import hdo_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic [2:0] operatingMode,
   input wire logic input_trigger_pin,
   input wire logic [7:0] analogLevel,
   input wire logic [7:0] amplitudeRequest,
   input wire logic resonanceHalfTick,
   input wire logic nvmAlreadyProgrammed,
   input wire logic nvmDone,
   output logic [7:0] driveAmplitude,
   output logic amplitudeUpdate,
   output logic resonant_open_loop_sel,
   output logic commutationLevel,
   output logic [10:0] calMinMs,
   output logic [10:0] calMaxMs,
   output logic nvmProgramReq,
   output logic [7:0] nvmFirstAddr,
   output logic [7:0] nvmLastAddr
);
   hdo_pin_if pins ();
   hdo_pin_meter meter
   (
      .clk(clk),
      .reset(reset),
      .input_trigger_pin(input_trigger_pin),
      .pins(pins)
   );

   logic lra_update_rate_sel_reg;
   logic lra_update_rate_sel_next;
   logic analogSel_reg;
   logic analogSel_next;
   logic openLoop_reg;
   logic openLoop_next;
   logic [1:0] calCode_reg;
   logic [1:0] calCode_next;
   logic programmed_reg;
   logic programmed_next;
   hdo_nvm_state_t nvmState_reg;
   hdo_nvm_state_t nvmState_next;
   logic strapSeen_reg;
   logic strapSeen_next;
   logic phase_reg;
   logic phase_next;
   logic [7:0] amp_reg;
   logic [7:0] amp_next;
   logic update_reg;
   logic update_next;
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;
   logic writeOpt;
   logic writeCal;
   logic halfTick;
   logic pinMode;
   logic [7:0] srcAmp;

   // one address decode shared by write strobes and read mux
   function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] target);
      hitAddr = (addr == target);
   endfunction : hitAddr

   assign writeOpt = regWrEn && hitAddr(regAddr, HDO_ADDR_DRIVE_OPT);
   assign writeCal = regWrEn && hitAddr(regAddr, HDO_ADDR_CAL_NVM);

   // upper bits of both registers are not stored
   always_comb
   begin
      lra_update_rate_sel_next = lra_update_rate_sel_reg;
      analogSel_next = analogSel_reg;
      openLoop_next = openLoop_reg;
      calCode_next = calCode_reg;
      if (writeOpt)
      begin
         lra_update_rate_sel_next = regWrData[HDO_BIT_UPDATE_RATE];
         analogSel_next = regWrData[HDO_BIT_INPUT_SEL];
         openLoop_next = regWrData[HDO_BIT_OPEN_LOOP];
      end
      if (writeCal)
      begin
         calCode_next = regWrData[HDO_BIT_CAL_LO +: 2];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lra_update_rate_sel_reg <= 1'b0;
         analogSel_reg <= 1'b0;
         openLoop_reg <= 1'b0;
         calCode_reg <= HDO_CAL_RESET;
      end
      else
      begin
         lra_update_rate_sel_reg <= lra_update_rate_sel_next;
         analogSel_reg <= analogSel_next;
         openLoop_reg <= openLoop_next;
         calCode_reg <= calCode_next;
      end
   end

   // strap sampled once after reset release, never under reset
   always_comb
   begin
      strapSeen_next = 1'b1;
      programmed_next = programmed_reg || (!strapSeen_reg && nvmAlreadyProgrammed);
      nvmState_next = nvmState_reg;
      unique case (nvmState_reg)
         HDO_NVM_IDLE:
            // a launch after programming is ignored for the life of the part
            if (writeCal && regWrData[HDO_BIT_LAUNCH] && !programmed_reg && strapSeen_reg)
               nvmState_next = HDO_NVM_BUSY;
         HDO_NVM_BUSY:
            if (nvmDone)
            begin
               nvmState_next = HDO_NVM_DONE;
               programmed_next = 1'b1;
            end
         HDO_NVM_DONE:
            nvmState_next = HDO_NVM_DONE;
         default:
            nvmState_next = HDO_NVM_DONE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         programmed_reg <= 1'b0;
         nvmState_reg <= HDO_NVM_IDLE;
         strapSeen_reg <= 1'b0;
      end
      else
      begin
         programmed_reg <= programmed_next;
         nvmState_reg <= nvmState_next;
         strapSeen_reg <= strapSeen_next;
      end
   end

   // open loop paces from the divided pwm, else from resonance tracking
   always_comb
   begin
      halfTick = openLoop_reg ? pins.commHalfTick : resonanceHalfTick;
      phase_next = halfTick ? !phase_reg : phase_reg;
      update_next = halfTick && (lra_update_rate_sel_reg || !phase_reg);
      pinMode = (operatingMode == HDO_MODE_PIN_INPUT);
      srcAmp = !pinMode ? amplitudeRequest
         : analogSel_reg ? analogLevel
         : pins.dutyLevel;
      amp_next = update_next ? srcAmp : amp_reg;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phase_reg <= 1'b0;
         amp_reg <= 8'h00;
         update_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         amp_reg <= amp_next;
         update_reg <= update_next;
      end
   end

   // registered read keeps the bus path short at the cost of one cycle
   always_comb
   begin
      rdData_next = 8'h00;
      if (hitAddr(regAddr, HDO_ADDR_DRIVE_OPT))
      begin
         rdData_next[HDO_BIT_UPDATE_RATE] = lra_update_rate_sel_reg;
         rdData_next[HDO_BIT_INPUT_SEL] = analogSel_reg;
         rdData_next[HDO_BIT_OPEN_LOOP] = openLoop_reg;
      end
      else if (hitAddr(regAddr, HDO_ADDR_CAL_NVM))
      begin
         rdData_next[HDO_BIT_CAL_LO +: 2] = calCode_reg;
         rdData_next[HDO_BIT_PROGRAMMED] = programmed_reg;
         rdData_next[HDO_BIT_LAUNCH] = (nvmState_reg == HDO_NVM_BUSY);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdData_reg <= 8'h00;
      end
      else
      begin
         rdData_reg <= rdData_next;
      end
   end

   assign regRdData = rdData_reg;
   assign driveAmplitude = amp_reg;
   assign amplitudeUpdate = update_reg;
   assign resonant_open_loop_sel = openLoop_reg;
   assign commutationLevel = pins.commLevel;
   assign calMinMs = hdo_cal_min_ms(calCode_reg);
   assign calMaxMs = hdo_cal_max_ms(calCode_reg);
   assign nvmProgramReq = (nvmState_reg == HDO_NVM_BUSY);
   assign nvmFirstAddr = HDO_NVM_FIRST;
   assign nvmLastAddr = HDO_NVM_LAST;
endmodule : hdo_drive_option_regs
`default_nettype wire

// [bench/hdo_drive_option_regs_sva.sv]
// port assertions for the drive option registers
`timescale 1ns/1ns
`default_nettype none
module hdo_drive_option_regs_sva
   import hdo_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic [2:0] operatingMode,
   input wire logic [7:0] amplitudeRequest,
   input wire logic nvmDone,
   input wire logic [7:0] driveAmplitude,
   input wire logic amplitudeUpdate,
   input wire logic [10:0] calMinMs,
   input wire logic [10:0] calMaxMs,
   input wire logic nvmProgramReq
);
   logic doneSeen;
   // cleared by reset: the strap guards later lives
   always_ff @(posedge clk) doneSeen <= !reset && (doneSeen || (nvmProgramReq && nvmDone));
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_RSV_DRIVE: assert property ($past(regAddr) == HDO_ADDR_DRIVE_OPT |-> regRdData[7:3] == 5'h00)
      else $error("drive option reserved bits set");
   AST_RSV_CAL: assert property ($past(regAddr) == HDO_ADDR_CAL_NVM |-> !regRdData[7] && !regRdData[6] && !regRdData[3] && !regRdData[1])
      else $error("cal register reserved bits set");
   AST_LAUNCH_CAUSE: assert property ($rose(nvmProgramReq) |-> $past(regWrEn && regAddr == HDO_ADDR_CAL_NVM && regWrData[0]))
      else $error("nvm copy without launch write");
   AST_LAUNCH_END: assert property (nvmProgramReq && nvmDone |=> !nvmProgramReq)
      else $error("nvm copy outlives done");
   AST_ONCE: assert property (doneSeen |-> !$rose(nvmProgramReq))
      else $error("second nvm copy");
   AST_CAL_SPAN: assert property (calMaxMs == calMinMs + 11'h0C8)
      else $error("cal bounds not 200 ms apart");
   AST_AMP_HOLD: assert property (!amplitudeUpdate |-> $stable(driveAmplitude))
      else $error("amplitude moved without update");
   AST_REQ_AMP: assert property (amplitudeUpdate && $past(operatingMode) != HDO_MODE_PIN_INPUT |-> driveAmplitude == $past(amplitudeRequest))
      else $error("amplitude not from request");
   cover property (amplitudeUpdate);
   cover property ($rose(nvmProgramReq));
   cover property (calMinMs == 11'h3E8);
endmodule : hdo_drive_option_regs_sva
`default_nettype wire

// [bench/hdo_pwm_source.sv]
// pwm source driving the input/trigger pin
`timescale 1ns/1ns
`default_nettype none
module hdo_pwm_source
(
   input wire logic clk,
   input wire logic [7:0] period,
   input wire logic [7:0] highCycles,
   output logic pin
);
   logic [7:0] phase_reg = 8'h00;
   // steady period keeps commutation at pin rate over 128
   always @(posedge clk) phase_reg <= (phase_reg + 8'h01 >= period) ? 8'h00 : phase_reg + 8'h01;
   assign pin = phase_reg < highCycles;
endmodule : hdo_pwm_source
`default_nettype wire

// [bench/hdo_drive_option_regs_tb.sv]
// self-checking bench for the drive option registers
`timescale 1ns/1ns
`default_nettype none
module hdo_drive_option_regs_tb;
   import hdo_pkg::*;
   logic clk = 1'b0, reset = 1'b1, regWrEn = 1'b0, resonanceHalfTick = 1'b0;
   logic nvmAlreadyProgrammed = 1'b0, nvmDone = 1'b0, rdTag = 1'b0, rdD = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, analogLevel = 8'h00;
   logic [7:0] amplitudeRequest = 8'h00, period = 8'h04, highCycles = 8'h02;
   logic [2:0] operatingMode = 3'h0;
   logic input_trigger_pin, amplitudeUpdate, resonant_open_loop_sel, commutationLevel;
   logic nvmProgramReq;
   logic [7:0] regRdData, driveAmplitude;
   logic [10:0] calMinMs, calMaxMs;
   logic [10:0] minTab [4] = '{11'h096, 11'h0FA, 11'h1F4, 11'h3E8};
   logic [10:0] maxTab [4] = '{11'h15E, 11'h1C2, 11'h2BC, 11'h4B0};
   logic [7:0] nvmFirstAddr, nvmLastAddr;
   logic [7:0] rdQ [$], ampQ [$];
   int err_count = 0, check_count = 0, cycles = 0, n = 0;
   integer seed = 32'hB299;
   bit ampOn = 1'b0;
   hdo_drive_option_regs hdo_drive_option_regs_i (.*);
   hdo_pwm_source hdo_pwm_source_i (.clk, .period, .highCycles, .pin(input_trigger_pin));
   always #5 clk = ~clk;
   task automatic complete_run();
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic compare(string name, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : compare
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      rdTag <= 1'b1;
      rdQ.push_back(e);
      @(posedge clk);
      rdTag <= 1'b0;
   endtask : rd
   // src 0 request, 1 analog level, 2 fixed duty
   task automatic tick(logic load, int src, logic [7:0] duty);
      logic [7:0] v;
      v = 8'($random(seed));
      @(posedge clk);
      amplitudeRequest <= v;
      analogLevel <= ~v;
      resonanceHalfTick <= 1'b1;
      if (load)
         ampQ.push_back(src == 0 ? v : (src == 1 ? ~v : duty));
      @(posedge clk);
      resonanceHalfTick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : tick
   task automatic waitToggle();
      logic lvl;
      lvl = commutationLevel;
      n = 0;
      while (commutationLevel === lvl && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : waitToggle
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      rdD <= rdTag;
      if (rdD)
         compare("regRdData", rdQ.pop_front(), regRdData);
      if (amplitudeUpdate === 1'b1 && ampOn)
         compare("driveAmplitude", ampQ.pop_front(), driveAmplitude);
      if (cycles == 20000)
      begin
         err_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      rd(HDO_ADDR_DRIVE_OPT, 8'h00);
      rd(HDO_ADDR_CAL_NVM, 8'h20);
      ampOn = 1'b1;
      for (int i = 0; i < 4; i++) tick(i % 2 == 0, 0, 8'h00);
      wr(HDO_ADDR_DRIVE_OPT, 8'hFC);
      rd(HDO_ADDR_DRIVE_OPT, 8'h04);
      for (int i = 0; i < 3; i++) tick(1'b1, 0, 8'h00);
      operatingMode <= HDO_MODE_PIN_INPUT;
      wr(HDO_ADDR_DRIVE_OPT, 8'h06);
      for (int i = 0; i < 3; i++) tick(1'b1, 1, 8'h00);
      wr(HDO_ADDR_DRIVE_OPT, 8'h04);
      highCycles <= 8'h04;
      repeat (600) @(posedge clk);
      tick(1'b1, 2, 8'hFF);
      highCycles <= 8'h00;
      repeat (600) @(posedge clk);
      tick(1'b1, 2, 8'h00);
      highCycles <= 8'h02;
      ampOn = 1'b0;
      wr(HDO_ADDR_DRIVE_OPT, 8'h05);
      @(posedge clk);
      compare("openLoop", 16'h0001, 16'(resonant_open_loop_sel));
      waitToggle();
      waitToggle();
      waitToggle();
      compare("commPeriod", 16'h0100, 16'(n));
      for (int c = 0; c < 4; c++)
      begin
         wr(HDO_ADDR_CAL_NVM, 8'hCE | 8'(c << 4));
         rd(HDO_ADDR_CAL_NVM, 8'(c << 4));
         compare("calMinMs", minTab[c], calMinMs);
         compare("calMaxMs", maxTab[c], calMaxMs);
      end
      // longest duration, single launch
      wr(HDO_ADDR_CAL_NVM, 8'h31);
      rd(HDO_ADDR_CAL_NVM, 8'h31);
      compare("nvmProgramReq", 16'h0001, 16'(nvmProgramReq));
      compare("nvmFirstAddr", 16'h0016, 16'(nvmFirstAddr));
      compare("nvmLastAddr", 16'h001A, 16'(nvmLastAddr));
      @(posedge clk) nvmDone <= 1'b1;
      @(posedge clk) nvmDone <= 1'b0;
      rd(HDO_ADDR_CAL_NVM, 8'h34);
      wr(HDO_ADDR_CAL_NVM, 8'h01);
      rd(HDO_ADDR_CAL_NVM, 8'h04);
      wr(8'h1F, 8'hFF);
      rd(HDO_ADDR_DRIVE_OPT, 8'h05);
      nvmAlreadyProgrammed <= 1'b1;
      reset <= 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      wr(HDO_ADDR_CAL_NVM, 8'h21);
      rd(HDO_ADDR_CAL_NVM, 8'h24);
      compare("nvmProgramReq", 16'h0000, 16'(nvmProgramReq));
      repeat (3) @(posedge clk);
      compare("pending", 16'h0000, 16'(ampQ.size() + rdQ.size()));
      complete_run();
   end
endmodule : hdo_drive_option_regs_tb
bind hdo_drive_option_regs hdo_drive_option_regs_sva hdo_drive_option_regs_sva_i (.*);
`default_nettype wire
